// ---- logic/dac_primary_config.sv ----
// Behaviour
// RULE1: Frame bit 31 high reads, low writes
// RULE2: Address 02h selects this register
// RULE3: Reset value is 004C80h
// RULE4: Bit 23 enables temperature calibration
// RULE5: Bits 22-20 reserved, read zero
// RULE6: Mask writable only when fast and enabled
// RULE7: Mask code maps to jump threshold
// RULE8: Hold disable zero means circuit active
// RULE9: Bit 10 selects settling mode
// RULE10: Locked mask keeps value, others update
`include "primary_config_cfg.svh"
`default_nettype none
module dac_primary_config
	import primary_config_pkg::*;
#(
	parameter int LOWER_WIDTH = 18
)(
	input wire logic clock, // 40 MHz system clock
	input wire logic rst_n, // Synchronous reset, power-on or software
	input wire logic linkClock, // Serial shift clock
	input wire logic selectN, // Frame select, active low
	input wire logic serialIn, // Serial data in
	input wire logic holdCircuitDisable, // Hold disable bit of the other register
	output logic [23:0] primaryConfig, // Register contents
	output logic tempCalibrationEnable, // Calibration enable
	output logic settlingModeSelect, // 1 enhanced distortion, 0 fast
	output logic [1:0] holdMaskThreshold, // Mask field
	output logic [20:0] holdJumpThreshold, // Code jump limit for masking
	output logic [23:0] readData, // Readback word for a read frame
	output logic readValid // One-cycle pulse per read frame to this address
);
	// Frame geometry, named so that the slices below read as fields
	localparam int FRAME_WIDTH = `FRAME_BITS;
	localparam int DATA_WIDTH = 24;
	localparam int ADDR_WIDTH = 7;
	localparam int THRESH_WIDTH = 21;
	localparam int SYNC_DEPTH = 2;

	// Reset contents and the address this register answers to
	localparam logic [DATA_WIDTH-1:0] RESET_VALUE = `PRIMARY_CONFIG_RESET; // RULE3
	localparam logic [ADDR_WIDTH-1:0] OWN_ADDR = `PRIMARY_CONFIG_ADDR; // RULE2

	// Jump limits for the four mask codes
	localparam logic [THRESH_WIDTH-1:0] THRESH_CODE0 = `HOLD_THRESH_00; // RULE7
	localparam logic [THRESH_WIDTH-1:0] THRESH_CODE1 = `HOLD_THRESH_01;
	localparam logic [THRESH_WIDTH-1:0] THRESH_CODE2 = `HOLD_THRESH_10;
	localparam logic [THRESH_WIDTH-1:0] THRESH_CODE3 = `HOLD_THRESH_11;

	// Link side results: the last whole frame and its completion toggle
	logic [FRAME_WIDTH-1:0] linkFrame;
	logic linkToggle;

	// Toggle synchroniser and the stage after it, used for edge detection
	logic [SYNC_DEPTH-1:0] togSync;
	logic togLast;
	logic frameEvent;

	// Frame fields on the link word, and the copy held in this domain
	frame_s frame;
	frame_s frameHeld;
	logic heldValid;

	// Access decode
	logic hitThis;
	logic writeHit;
	logic readHit;

	// Register storage, write policy and next value
	logic [DATA_WIDTH-1:0] cfg;
	logic [DATA_WIDTH-1:0] next_cfg;
	logic [DATA_WIDTH-1:0] takeNew;
	logic [DATA_WIDTH-1:0] forceZero;
	logic maskOpen;

	// Field views of the stored register
	logic cfgCal;
	logic [1:0] cfgMask;
	logic cfgSettle;
	logic [LOWER_WIDTH-1:0] cfgLower;

	// Readback word assembled from the field views
	logic [DATA_WIDTH-1:0] readWord;

	// Shift register on the link clock; what it hands over waits for the toggle
	frame_capture capture (
		.linkClock(linkClock),
		.selectN(selectN),
		.serialIn(serialIn),
		.frameWord(linkFrame),
		.frameToggle(linkToggle)
	);

	// Two flops take the toggle into this domain. No reset here: clearing them
	// while the link toggle sits high would invent a frame when reset lets go.
	always_ff @(posedge clock) begin
		togSync <= {togSync[SYNC_DEPTH-2:0], linkToggle};
		togLast <= togSync[SYNC_DEPTH-1];
	end

	// One pulse per whole frame; the link word has been still for two cycles by now
	assign frameEvent = togSync[SYNC_DEPTH-1] ^ togLast;

	// Link word split into its fields; it only changes between toggles
	assign frame = '{
		readReq: linkFrame[`FRAME_RW_BIT],
		addr: linkFrame[`FRAME_ADDR_HI:`FRAME_ADDR_LO],
		data: linkFrame[DATA_WIDTH-1:0]
	};

	// Frame copied on the event, so no decode reads across the clock boundary
	always_ff @(posedge clock) begin
		if (frameEvent) begin
			frameHeld <= frame;
		end
	end

	// Marks the cycle in which the held copy is fresh
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			heldValid <= 1'b0;
		end else begin
			heldValid <= frameEvent;
		end
	end

	// Address match first, then the direction bit picks read or write
	assign hitThis = (frameHeld.addr == OWN_ADDR); // RULE2
	assign writeHit = heldValid && hitThis && !frameHeld.readReq; // RULE1
	assign readHit = heldValid && hitThis && frameHeld.readReq; // RULE1

	// The mask lock opens only for fast settling with the hold circuit running
	assign maskOpen = !cfgSettle && !holdCircuitDisable; // RULE6 RULE8

	// Per-bit write policy and storage; each bit knows which field it belongs to
	for (genvar b = 0; b < DATA_WIDTH; b++) begin : g_bit
		localparam bit IS_CAL = (b == `TEMP_CAL_BIT);
		localparam bit IS_RSVD = (b >= `RSVD_LO) && (b <= `RSVD_HI);
		localparam bit IS_MASK = (b >= `HOLD_MASK_LO) && (b <= `HOLD_MASK_HI);
		localparam bit IS_LOWER = (b < LOWER_WIDTH);

		// Enable and lower fields always follow a write; the mask only while unlocked
		assign takeNew[b] = IS_CAL || IS_LOWER || (IS_MASK && maskOpen); // RULE4 RULE10
		// Reserved bits are stored as zero whatever the host sends
		assign forceZero[b] = IS_RSVD; // RULE5
		assign next_cfg[b] = forceZero[b] ? 1'b0 : (takeNew[b] ? frameHeld.data[b] : cfg[b]);

		// One flop per bit, loaded only by a write frame to this address
		always_ff @(posedge clock) begin
			if (!rst_n) begin
				cfg[b] <= RESET_VALUE[b]; // RULE3
			end else if (writeHit) begin
				cfg[b] <= next_cfg[b];
			end
		end
	end

	// Field views of the stored word
	assign cfgCal = cfg[`TEMP_CAL_BIT]; // RULE4
	assign cfgMask = cfg[`HOLD_MASK_HI:`HOLD_MASK_LO];
	assign cfgSettle = cfg[`SETTLING_BIT]; // RULE9
	assign cfgLower = cfg[LOWER_WIDTH-1:0];

	// Readback rebuilt from the fields, so reserved bits read zero by construction
	assign readWord = {cfgCal, 3'h0, cfgMask, cfgLower}; // RULE5

	// Read answer: a one-cycle strobe; the data holds until the next read
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			readData <= 24'h000000;
			readValid <= 1'b0;
		end else begin
			readValid <= readHit; // RULE1
			if (readHit) begin
				readData <= readWord;
			end
		end
	end

	// Field outputs straight from the flops
	assign primaryConfig = cfg;
	assign tempCalibrationEnable = cfgCal; // RULE4
	assign settlingModeSelect = cfgSettle; // RULE9
	assign holdMaskThreshold = cfgMask;

	// Threshold decode; the table order is not monotonic in the code
	always_comb begin
		case (cfgMask)
			2'b00: holdJumpThreshold = THRESH_CODE0; // RULE7
			2'b01: holdJumpThreshold = THRESH_CODE1;
			2'b10: holdJumpThreshold = THRESH_CODE2;
			2'b11: holdJumpThreshold = THRESH_CODE3;
			default: holdJumpThreshold = THRESH_CODE0;
		endcase
	end
endmodule
`default_nettype wire

// ---- logic/primary_config_cfg.svh ----
`ifndef PRIMARY_CONFIG_CFG_SVH
`define PRIMARY_CONFIG_CFG_SVH
`define FRAME_BITS 32
`define FRAME_RW_BIT 31
`define FRAME_ADDR_HI 30
`define FRAME_ADDR_LO 24
`define PRIMARY_CONFIG_ADDR 7'h02
`define PRIMARY_CONFIG_RESET 24'h004c80
`define TEMP_CAL_BIT 23
`define RSVD_HI 22
`define RSVD_LO 20
`define HOLD_MASK_HI 19
`define HOLD_MASK_LO 18
`define SETTLING_BIT 10
`define HOLD_THRESH_00 21'h004000
`define HOLD_THRESH_01 21'h008000
`define HOLD_THRESH_10 21'h002000
`define HOLD_THRESH_11 21'h001000
`endif

// ---- logic/primary_config_pkg.sv ----
`default_nettype none
package primary_config_pkg;
	// One decoded host frame, carried across the clock boundary as a unit
	typedef struct packed {
		logic readReq;
		logic [6:0] addr;
		logic [23:0] data;
	} frame_s;
endpackage
`default_nettype wire

// ---- logic/frame_capture.sv ----
`default_nettype none
// Shifts a 32-bit frame on the link clock and hands it over by toggle
module frame_capture
	import primary_config_pkg::*;
(
	input wire logic linkClock, // Serial shift clock from the host
	input wire logic selectN, // Frame select, active low
	input wire logic serialIn, // Serial data, MSB first
	output logic [31:0] frameWord, // Last complete frame
	output logic frameToggle // Flips once per complete frame
);
	logic [31:0] shiftReg;
	logic [5:0] bitCount;
	logic toggle = 1'b0; // Power-up value; the link side has no reset of its own
	wire [31:0] next_shift = {shiftReg[30:0], serialIn};
	wire frameDone = (bitCount == 6'd31);

	// Select high clears the count at once, so a cut frame cannot put the next one out of step
	always_ff @(posedge linkClock or posedge selectN) begin
		if (selectN) begin
			bitCount <= 6'd0;
		end else begin
			bitCount <= frameDone ? 6'd0 : bitCount + 6'd1;
		end
	end

	// The link clock only runs inside frames, so the frame ends on the last bit, not on select release
	always_ff @(posedge linkClock) begin
		if (!selectN) begin
			shiftReg <= next_shift;
			if (frameDone) begin
				frameWord <= next_shift;
				toggle <= ~toggle;
			end
		end
	end

	assign frameToggle = toggle;
endmodule
`default_nettype wire

// ---- verif/primary_config_checker.sv ----
`default_nettype none
module primary_config_checker(
	input wire logic clock, // Clock
	input wire logic rst_n, // Reset
	input wire logic holdCircuitDisable, // Lock
	input wire logic [23:0] primaryConfig, // Reg
	input wire logic tempCalibrationEnable, // Bit 23
	input wire logic settlingModeSelect, // Bit 10
	input wire logic [20:0] holdJumpThreshold, // Limit
	input wire logic [23:0] readData, // Readback
	input wire logic readValid // Pulse
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Locked unless fast settling with the hold circuit on
	sequence lockedS; settlingModeSelect || holdCircuitDisable; endsequence
	// Jump limit expected for the stored mask code
	wire logic [20:0] thrOf = primaryConfig[19:18] == 2'h0 ? 21'h004000 : primaryConfig[19:18] == 2'h1 ?
		21'h008000 : primaryConfig[19:18] == 2'h2 ? 21'h002000 : 21'h001000;
	rst_val_a: assert property ($rose(rst_n) |-> primaryConfig == 24'h004c80) else $error("reset");
	temp_bit_a: assert property (tempCalibrationEnable == primaryConfig[23]) else $error("cal");
	rsvd_zero_a: assert property (primaryConfig[22:20] == 3'h0) else $error("rsvd");
	settle_bit_a: assert property (settlingModeSelect == primaryConfig[10]) else $error("set");
	mask_lock_a: assert property (lockedS ##1 1 |-> $stable(primaryConfig[19:18])) else $error("lock");
	thr_map_a: assert property (holdJumpThreshold == thrOf) else $error("thr");
	read_pulse_a: assert property (readValid |=> !readValid) else $error("pulse");
	read_data_a: assert property (readValid |-> readData == primaryConfig) else $error("rdata");
endmodule
bind dac_primary_config primary_config_checker i_chk(.clock, .rst_n, .holdCircuitDisable, .primaryConfig,
	.tempCalibrationEnable, .settlingModeSelect, .holdJumpThreshold, .readData, .readValid);
`default_nettype wire

// ---- verif/host_model.sv ----
`default_nettype none
module host_model(
	output logic linkClock, // Still outside frames
	output logic selectN, // Select
	output logic serialIn // MSB first
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {linkClock, selectN, serialIn} = 3'h2;
	// Flag bit 31, address 30:24, then data
	task automatic send(input logic [31:0] f);
		#3 selectN = 1'b0;
		for (int i = 31; i >= 0; i--) begin
			serialIn = f[i];
			#40 linkClock = 1'b1;
			#40 linkClock = 1'b0;
		end
		#40 selectN = 1'b1;
		// Released line must not look like a held bit
		serialIn = ~serialIn;
	endtask
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock, rst_n, holdCircuitDisable, linkClock, selectN, serialIn, readValid;
	logic tempCal, settle, seen;
	logic [1:0] mask;
	logic [23:0] primaryConfig, readData, exp, d;
	logic [20:0] holdJumpThreshold;
	logic [6:0] a;
	logic [31:0] r = 32'h60ce;
	int miscompares = 0, num_checks = 0, cyc = 0;
	dac_primary_config i_dac_primary_config(.clock, .rst_n, .linkClock, .selectN, .serialIn, .holdCircuitDisable,
		.primaryConfig, .tempCalibrationEnable(tempCal), .settlingModeSelect(settle), .holdMaskThreshold(mask),
		.holdJumpThreshold,
		.readData, .readValid);
	host_model host(.linkClock, .selectN, .serialIn);
	task chk(input logic [23:0] g, e);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %0t got %h want %h", $time, g, e);
		end
	endtask
	task report_and_stop;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Jump limit per mask code
	function automatic logic [20:0] thr(input logic [1:0] c);
		case (c)
			2'h0: return 21'h004000;
			2'h1: return 21'h008000;
			2'h2: return 21'h002000;
			default: return 21'h001000;
		endcase
	endfunction
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// Read frame; the pulse is watched while the frame is still being sent
	task rd;
		fork
			host.send(32'h82000000);
			begin
				for (int k = 0; k < 200 && readValid !== 1'b1; k++) @(negedge clock);
				seen = readValid;
			end
		join
		chk({23'h0, seen}, 24'h1);
		chk(readData, exp);
		chk(primaryConfig, exp);
		chk({23'h0, tempCal}, {23'h0, exp[23]});
		chk({23'h0, settle}, {23'h0, exp[10]});
		chk({22'h0, mask}, {22'h0, exp[19:18]});
		chk({3'h0, holdJumpThreshold}, {3'h0, thr(exp[19:18])});
	endtask
	initial begin
		clock = 0;
		forever #12.5 clock = ~clock;
	end
	// Frames take about 210 cycles a loop; far above that is a hang
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			report_and_stop;
		end
	end
	initial begin
		{rst_n, holdCircuitDisable, exp} = {2'h0, 24'h004c80};
		repeat (6) @(posedge clock);
		rst_n <= 1;
		rd;
		for (int i = 0; i < 14; i++) begin
			r = lfsr(r);
			@(posedge clock);
			holdCircuitDisable <= r[31] & r[30];
			a = i % 5 == 4 ? 7'h03 : 7'h02;
			d = r[23:0] & (i < 2 ? 24'h8ffbff : 24'h8fffff);
			#1 host.send({1'b0, a, d});
			if (a == 7'h02) exp = {d[23], 3'h0, ((exp[10] | holdCircuitDisable) ? exp[19:18] : d[19:18]), d[17:0]};
			rd;
		end
		report_and_stop;
	end
endmodule
`default_nettype wire
